/* File: core/pca_top.sv */
// Purpose: Pad configuration registers and port A behind an AHB-Lite slave
// Assumes: Single 40 MHz clock, synchronous active-high reset, word transfers
// Notes: Reads take one wait state, writes none; outputs registered except the constant hresp and pa_schmitt_en
//
// Functional notes
// RULE1 - Open-drain only when peripheral enable set
// RULE2 - First register: capture/PWM enables bits 4-0
// RULE3 - Second register: UART transmit enables bits 1-0
// RULE4 - Third register: SPI data out enables 1-0
// RULE5 - Unimplemented bits read zero, ignore writes
// RULE6 - Implemented bits read/write, reset to zero
// RULE7 - Open-drain registers share timer one addresses
// RULE8 - Pad config shares timer two count address
// RULE9 - Pad bit 0 selects TTL parallel inputs
// RULE10 - Port A eight bits, fewer with oscillator
// RULE11 - Analog config bits pick analog or digital
// RULE12 - Reset: analog pins read zero, pin4 digital
// RULE13 - Pin 4 Schmitt, others TTL push-pull
// RULE14 - Direction still controls analog pins
// RULE15 - External oscillator hides pins six, seven
// RULE16 - Internal oscillator codes pick upper pin use
// RULE17 - Pin six outputs clock over four
// RULE18 - Upper pin bits defined only as I/O
// RULE19 - External pull-up needed for open drain
// RULE20 - Direction one is input, zero drives latch
// RULE21 - Port read gives pins, write hits latch
// RULE22 - Open drain pulls low, releases for one
`timescale 1ns/1ps

module pca_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] pa_in,
   output logic [7:0] pa_out,
   output logic [7:0] pa_oe_n,
   output logic [7:0] pa_analog_en,
   output logic [7:0] pa_schmitt_en,
   input wire logic [8:0] per_data,
   input wire logic [8:0] per_drive,
   output logic [8:0] per_pad_out,
   output logic [8:0] per_pad_oe_n,
   output logic pmp_ttl_sel
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      pca_pkg::pca_bus_t bus;
      logic [7:0] ph_addr;
      logic shared_sel;
      logic [pca_pkg::OD1_W-1:0] od1;
      logic [pca_pkg::OD2_W-1:0] od2;
      logic [pca_pkg::OD3_W-1:0] od3;
      logic pad_ttl;
      logic [7:0] t1l;
      logic [7:0] t1h;
      logic [7:0] t1c;
      logic [7:0] t2;
      logic [pca_pkg::ANA_W-1:0] ana_dig;
      logic [7:0] dir;
      logic [7:0] lat;
      logic [pca_pkg::OSC_W-1:0] osc;
      logic [1:0] div_cnt;
      logic divided_clock_out;
      logic hready;
      logic [31:0] hrdata;
      logic [7:0] pa_out;
      logic [7:0] pa_oe_n;
      logic [7:0] pa_analog;
      logic [8:0] per_out;
      logic [8:0] per_oe_n;
   } pca_state_t;

   pca_state_t st_reg;
   pca_state_t st_next;

   pca_cfg_if cfg_if ();

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode, used for both the write and the read path

   function automatic logic [3:0] pca_decode(input logic [7:0] addr, input logic sel);
      logic [3:0] id;
      id = pca_pkg::RID_NONE;
      case (addr)
         pca_pkg::OFF_WDT: id = pca_pkg::RID_WDT;
         pca_pkg::OFF_SH_T1L: id = sel ? pca_pkg::RID_OD1 : pca_pkg::RID_T1L; // RULE7
         pca_pkg::OFF_SH_T1H: id = sel ? pca_pkg::RID_OD2 : pca_pkg::RID_T1H; // RULE7
         pca_pkg::OFF_SH_T1C: id = sel ? pca_pkg::RID_OD3 : pca_pkg::RID_T1C; // RULE7
         pca_pkg::OFF_SH_T2: id = sel ? pca_pkg::RID_PAD : pca_pkg::RID_T2; // RULE8
         pca_pkg::OFF_ANA: id = pca_pkg::RID_ANA;
         pca_pkg::OFF_DIR: id = pca_pkg::RID_DIR;
         pca_pkg::OFF_LAT: id = pca_pkg::RID_LAT;
         pca_pkg::OFF_PINS: id = pca_pkg::RID_PINS;
         pca_pkg::OFF_OSC: id = pca_pkg::RID_OSC;
         default: id = pca_pkg::RID_NONE;
      endcase
      return id;
   endfunction : pca_decode

   ////////////////////////////////////////////////////////////////////////////////
   // Pad logic

   assign cfg_if.dir = st_reg.dir;
   assign cfg_if.lat = st_reg.lat;
   assign cfg_if.pins_in = pa_in;
   assign cfg_if.ana_dig = st_reg.ana_dig;
   assign cfg_if.osc = st_reg.osc;
   assign cfg_if.divided_clock_out = st_reg.divided_clock_out;
   assign cfg_if.od_en = {st_reg.od3, st_reg.od2, st_reg.od1};
   assign cfg_if.per_data = per_data;
   assign cfg_if.per_drive = per_drive;

   pca_port_a u_port_a (
      .bus(cfg_if.port)
   );

   pca_od_pad u_od_pad (
      .bus(cfg_if.od)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   logic addr_phase;
   logic [3:0] wr_id;
   logic [3:0] rd_id;
   logic [7:0] rd_byte;
   logic [7:0] wdata;

   always_comb begin
      st_next = st_reg;
      addr_phase = hsel && htrans[1] && hready;
      wdata = hwdata[7:0];
      wr_id = pca_decode(st_reg.ph_addr, st_reg.shared_sel);
      rd_id = wr_id;
      rd_byte = 8'h00;

      // Fosc/4 from the system clock
      if (st_reg.div_cnt == pca_pkg::DIVIDED_CLOCK_OUT_HALF) begin // RULE17
         st_next.div_cnt = 2'h0;
         st_next.divided_clock_out = ~st_reg.divided_clock_out;
      end else begin
         st_next.div_cnt = st_reg.div_cnt + 2'h1;
      end

      // Write data phase; narrow fields drop the upper bits
      if (st_reg.bus == pca_pkg::BUS_WR) begin
         case (wr_id)
            pca_pkg::RID_WDT: st_next.shared_sel = wdata[pca_pkg::WDT_SEL_BIT];
            pca_pkg::RID_OD1: st_next.od1 = wdata[pca_pkg::OD1_W-1:0]; // RULE2 RULE5 RULE6
            pca_pkg::RID_OD2: st_next.od2 = wdata[pca_pkg::OD2_W-1:0]; // RULE3 RULE5 RULE6
            pca_pkg::RID_OD3: st_next.od3 = wdata[pca_pkg::OD3_W-1:0]; // RULE4 RULE5 RULE6
            pca_pkg::RID_PAD: st_next.pad_ttl = wdata[pca_pkg::PAD_TTL_BIT]; // RULE9 RULE5
            pca_pkg::RID_T1L: st_next.t1l = wdata;
            pca_pkg::RID_T1H: st_next.t1h = wdata;
            pca_pkg::RID_T1C: st_next.t1c = wdata;
            pca_pkg::RID_T2: st_next.t2 = wdata;
            pca_pkg::RID_ANA: st_next.ana_dig = wdata[pca_pkg::ANA_W-1:0]; // RULE11
            pca_pkg::RID_DIR: st_next.dir = wdata;
            pca_pkg::RID_LAT: st_next.lat = wdata;
            pca_pkg::RID_PINS: st_next.lat = wdata; // RULE21
            pca_pkg::RID_OSC: st_next.osc = wdata[pca_pkg::OSC_W-1:0];
            default: st_next.lat = st_reg.lat;
         endcase
      end

      // Read data; upper pin bits masked while they are not I/O
      case (rd_id)
         pca_pkg::RID_WDT: rd_byte = 8'(st_reg.shared_sel) << pca_pkg::WDT_SEL_BIT;
         pca_pkg::RID_OD1: rd_byte = {3'h0, st_reg.od1}; // RULE2 RULE5
         pca_pkg::RID_OD2: rd_byte = {6'h00, st_reg.od2}; // RULE3 RULE5
         pca_pkg::RID_OD3: rd_byte = {6'h00, st_reg.od3}; // RULE4 RULE5
         pca_pkg::RID_PAD: rd_byte = {7'h00, st_reg.pad_ttl}; // RULE5 RULE9
         pca_pkg::RID_T1L: rd_byte = st_reg.t1l;
         pca_pkg::RID_T1H: rd_byte = st_reg.t1h;
         pca_pkg::RID_T1C: rd_byte = st_reg.t1c;
         pca_pkg::RID_T2: rd_byte = st_reg.t2;
         pca_pkg::RID_ANA: rd_byte = {3'h0, st_reg.ana_dig};
         pca_pkg::RID_DIR: rd_byte = st_reg.dir & cfg_if.io_mask; // RULE15 RULE18
         pca_pkg::RID_LAT: rd_byte = st_reg.lat & cfg_if.io_mask; // RULE15 RULE18
         pca_pkg::RID_PINS: rd_byte = cfg_if.pins_rd; // RULE21 RULE12
         pca_pkg::RID_OSC: rd_byte = {5'h00, st_reg.osc};
         default: rd_byte = 8'h00;
      endcase

      // Bus sequencing: reads wait one cycle so a preceding write is visible
      st_next.hready = 1'b1;
      case (st_reg.bus)
         pca_pkg::BUS_RD: begin
            st_next.hrdata = {24'h000000, rd_byte};
            st_next.bus = pca_pkg::BUS_IDLE;
         end
         pca_pkg::BUS_IDLE,
         pca_pkg::BUS_WR: begin
            st_next.bus = pca_pkg::BUS_IDLE;
            if (addr_phase) begin
               st_next.ph_addr = haddr[7:0];
               if (hwrite) begin
                  st_next.bus = pca_pkg::BUS_WR;
               end else begin
                  st_next.bus = pca_pkg::BUS_RD;
                  st_next.hready = 1'b0;
               end
            end
         end
         default: st_next.bus = pca_pkg::BUS_IDLE;
      endcase

      // Pad outputs registered from the pad logic
      st_next.pa_out = cfg_if.pa_out;
      st_next.pa_oe_n = cfg_if.pa_oe_n;
      st_next.pa_analog = cfg_if.pa_analog;
      st_next.per_out = cfg_if.per_out;
      st_next.per_oe_n = cfg_if.per_oe_n;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg.bus <= pca_pkg::BUS_IDLE;
         st_reg.ph_addr <= 8'h00;
         st_reg.shared_sel <= 1'b0;
         st_reg.od1 <= pca_pkg::RST_OD[pca_pkg::OD1_W-1:0]; // RULE6
         st_reg.od2 <= pca_pkg::RST_OD[pca_pkg::OD2_W-1:0]; // RULE6
         st_reg.od3 <= pca_pkg::RST_OD[pca_pkg::OD3_W-1:0]; // RULE6
         st_reg.pad_ttl <= 1'b0; // RULE6 RULE9
         st_reg.t1l <= pca_pkg::RST_TMR;
         st_reg.t1h <= pca_pkg::RST_TMR;
         st_reg.t1c <= pca_pkg::RST_TMR;
         st_reg.t2 <= pca_pkg::RST_TMR;
         st_reg.ana_dig <= pca_pkg::RST_ANA; // RULE12
         st_reg.dir <= pca_pkg::RST_DIR; // RULE12
         st_reg.lat <= pca_pkg::RST_LAT;
         st_reg.osc <= pca_pkg::RST_OSC;
         st_reg.div_cnt <= 2'h0;
         st_reg.divided_clock_out <= 1'b0;
         st_reg.hready <= 1'b1;
         st_reg.hrdata <= 32'h00000000;
         st_reg.pa_out <= 8'h00;
         st_reg.pa_oe_n <= 8'hFF;
         st_reg.pa_analog <= 8'h2F;
         st_reg.per_out <= 9'h000;
         st_reg.per_oe_n <= 9'h1FF;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign hreadyout = st_reg.hready;
   assign hresp = 1'b0;
   assign hrdata = st_reg.hrdata;
   assign pa_out = st_reg.pa_out;
   assign pa_oe_n = st_reg.pa_oe_n;
   assign pa_analog_en = st_reg.pa_analog;
   assign pa_schmitt_en = pca_pkg::SCHMITT_PINS; // RULE13
   assign per_pad_out = st_reg.per_out;
   assign per_pad_oe_n = st_reg.per_oe_n;
   assign pmp_ttl_sel = st_reg.pad_ttl; // RULE9

endmodule : pca_top

/* File: core/pca_pkg.sv */
// Purpose: Shared constants and types for the pad configuration and port A block
// Assumes: 40 MHz system clock, AHB-Lite register access, 8-bit registers in 32-bit words
// Notes: Register offsets are byte addresses on the bus

package pca_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses, low eight bits of haddr)
   localparam logic [7:0] OFF_WDT = 8'h00;
   localparam logic [7:0] OFF_SH_T1L = 8'h04;
   localparam logic [7:0] OFF_SH_T1H = 8'h08;
   localparam logic [7:0] OFF_SH_T1C = 8'h0C;
   localparam logic [7:0] OFF_SH_T2 = 8'h10;
   localparam logic [7:0] OFF_ANA = 8'h14;
   localparam logic [7:0] OFF_DIR = 8'h18;
   localparam logic [7:0] OFF_LAT = 8'h1C;
   localparam logic [7:0] OFF_PINS = 8'h20;
   localparam logic [7:0] OFF_OSC = 8'h24;

   // Register identities after decode
   localparam logic [3:0] RID_NONE = 4'h0;
   localparam logic [3:0] RID_WDT = 4'h1;
   localparam logic [3:0] RID_OD1 = 4'h2;
   localparam logic [3:0] RID_OD2 = 4'h3;
   localparam logic [3:0] RID_OD3 = 4'h4;
   localparam logic [3:0] RID_PAD = 4'h5;
   localparam logic [3:0] RID_T1L = 4'h6;
   localparam logic [3:0] RID_T1H = 4'h7;
   localparam logic [3:0] RID_T1C = 4'h8;
   localparam logic [3:0] RID_T2 = 4'h9;
   localparam logic [3:0] RID_ANA = 4'hA;
   localparam logic [3:0] RID_DIR = 4'hB;
   localparam logic [3:0] RID_LAT = 4'hC;
   localparam logic [3:0] RID_PINS = 4'hD;
   localparam logic [3:0] RID_OSC = 4'hE;

   ////////////////////////////////////////////////////////////////////////////////
   // Field layout
   localparam int WDT_SEL_BIT = 4;
   localparam int OD1_W = 5;
   localparam int OD2_W = 2;
   localparam int OD3_W = 2;
   localparam int PAD_TTL_BIT = 0;
   localparam int ANA_W = 5;
   localparam int OSC_W = 3;
   localparam int OSC_EXT_BIT = 2;
   localparam int PER_N = OD1_W + OD2_W + OD3_W;
   localparam int PA_W = 8;

   // Reset values
   localparam logic [7:0] RST_OD = 8'h00;
   localparam logic [7:0] RST_TMR = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_LAT = 8'h00;
   localparam logic [ANA_W-1:0] RST_ANA = 5'h00;
   localparam logic [OSC_W-1:0] RST_OSC = 3'h0;
   localparam logic [7:0] SCHMITT_PINS = 8'h10;

   // Oscillator codes with internal source
   localparam logic [OSC_W-1:0] OSC_PLL_CLKOUT = 3'h3;
   localparam logic [OSC_W-1:0] OSC_PLL_IO = 3'h2;
   localparam logic [OSC_W-1:0] OSC_INT_CLKOUT = 3'h1;
   localparam logic [OSC_W-1:0] OSC_INT_IO = 3'h0;

   // Divided clock output: system clock over four, toggles every half period
   localparam int DIVIDED_CLOCK_OUT_DIV = 4;
   localparam logic [1:0] DIVIDED_CLOCK_OUT_HALF = 2'(DIVIDED_CLOCK_OUT_DIV / 2 - 1);

   // Bus slave sequencing
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WR = 3'b010,
      BUS_RD = 3'b100
   } pca_bus_t;

   // Analog-capable pins: bit set in the config means digital
   function automatic logic [7:0] pca_analog_mask(input logic [ANA_W-1:0] dig);
      pca_analog_mask = {2'b00, ~dig[4], 1'b0, ~dig[3:0]};
   endfunction : pca_analog_mask

endpackage : pca_pkg

/* File: core/pca_cfg_if.sv */
// Purpose: Carrier between the register core and the pad logic
// Assumes: All signals combinational within one clock
// Notes: cfg drives settings, port and od return pad controls
`timescale 1ns/1ps

interface pca_cfg_if;
   logic [pca_pkg::PA_W-1:0] dir;
   logic [pca_pkg::PA_W-1:0] lat;
   logic [pca_pkg::PA_W-1:0] pins_in;
   logic [pca_pkg::ANA_W-1:0] ana_dig;
   logic [pca_pkg::OSC_W-1:0] osc;
   logic divided_clock_out;
   logic [pca_pkg::PA_W-1:0] pa_out;
   logic [pca_pkg::PA_W-1:0] pa_oe_n;
   logic [pca_pkg::PA_W-1:0] pa_analog;
   logic [pca_pkg::PA_W-1:0] io_mask;
   logic [pca_pkg::PA_W-1:0] pins_rd;
   logic [pca_pkg::PER_N-1:0] od_en;
   logic [pca_pkg::PER_N-1:0] per_data;
   logic [pca_pkg::PER_N-1:0] per_drive;
   logic [pca_pkg::PER_N-1:0] per_out;
   logic [pca_pkg::PER_N-1:0] per_oe_n;

   modport cfg (output dir, lat, pins_in, ana_dig, osc, divided_clock_out, od_en, per_data, per_drive,
      input pa_out, pa_oe_n, pa_analog, io_mask, pins_rd, per_out, per_oe_n);
   modport port (input dir, lat, pins_in, ana_dig, osc, divided_clock_out,
      output pa_out, pa_oe_n, pa_analog, io_mask, pins_rd);
   modport od (input od_en, per_data, per_drive, output per_out, per_oe_n);
endinterface : pca_cfg_if

/* File: core/pca_od_pad.sv */
// Purpose: Push-pull or open-drain drive for peripheral output pins
// Assumes: Peripherals give a data bit and a drive request per pin
// Notes: Output enable is active low
`timescale 1ns/1ps

module pca_od_pad (
   pca_cfg_if.od bus
);
   genvar i;
   generate
      for (i = 0; i < pca_pkg::PER_N; i++) begin : g_pin
         // Open drain never drives high; a one releases the line to the pull-up
         assign bus.per_out[i] = bus.od_en[i] ? 1'b0 : bus.per_data[i]; // RULE1 RULE22
         assign bus.per_oe_n[i] = ~bus.per_drive[i] |
            (bus.od_en[i] & bus.per_data[i]); // RULE1 RULE22
      end
   endgenerate
endmodule : pca_od_pad

/* File: core/pca_port_a.sv */
// Purpose: Port A pin direction, analog selection and oscillator pin takeover
// Assumes: Pin inputs synchronous to the clock
// Notes: Purely combinational; the top registers every result
`timescale 1ns/1ps

module pca_port_a (
   pca_cfg_if.port bus
);
   logic osc_int;
   logic pin6_io;
   logic pin7_io;
   logic divided_clock_out_on;

   assign osc_int = ~bus.osc[pca_pkg::OSC_EXT_BIT];
   assign pin6_io = osc_int &&
      (bus.osc == pca_pkg::OSC_INT_IO || bus.osc == pca_pkg::OSC_PLL_IO); // RULE16
   assign pin7_io = osc_int; // RULE15 RULE16
   assign divided_clock_out_on = osc_int && !pin6_io; // RULE17
   assign bus.io_mask = {pin7_io, pin6_io, 6'h3F}; // RULE10
   assign bus.pa_analog = pca_pkg::pca_analog_mask(bus.ana_dig); // RULE11

   // Analog pins and oscillator pins read low
   assign bus.pins_rd = bus.pins_in & bus.io_mask & ~bus.pa_analog; // RULE12 RULE18 RULE21

   genvar i;
   generate
      for (i = 0; i < pca_pkg::PA_W; i++) begin : g_pin
         if (i == 6) begin : g_divided_clock_out
            assign bus.pa_out[i] = divided_clock_out_on ? bus.divided_clock_out : bus.lat[i]; // RULE17
            assign bus.pa_oe_n[i] = divided_clock_out_on ? 1'b0 : (pin6_io ? bus.dir[i] : 1'b1);
         end else begin : g_io
            assign bus.pa_out[i] = bus.lat[i]; // RULE20
            // Direction still rules analog pins
            assign bus.pa_oe_n[i] = bus.io_mask[i] ? bus.dir[i] : 1'b1; // RULE14 RULE20
         end
      end
   endgenerate
endmodule : pca_port_a

/* File: tb/pca_top_sva.sv */
// Purpose: Bus timing and pad drive checks on pca_top
// Assumes: One clock, rst synchronous and active high
// Notes: Bound to every pca_top instance
`timescale 1ns/1ps

module pca_top_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic [7:0] pa_analog_en,
   input wire logic [7:0] pa_schmitt_en,
   input wire logic [8:0] per_data,
   input wire logic [8:0] per_drive,
   input wire logic [8:0] per_pad_out,
   input wire logic [8:0] per_pad_oe_n,
   input wire logic pmp_ttl_sel
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   wire logic rd_take = hsel && htrans[1] && hready && !hwrite;
   wire logic wr_take = hsel && htrans[1] && hready && hwrite;
   // Both drive modes must pull a low data bit down
   wire logic [8:0] pull_low = per_drive & ~per_data;

   ////////////////////////////////////////
   read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read without exactly one wait state");
   write_ready_a: assert property (wr_take |=> hreadyout)
      else $error("write data phase stalled");
   wait_once_a: assert property ($fell(hreadyout) |=> $rose(hreadyout))
      else $error("wait state longer than one cycle");
   upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_take, 2))
      else $error("read data changed without a read");
   schmitt_fixed_a: assert property (pa_schmitt_en == 8'h10)
      else $error("input buffer kind wrong");
   analog_pins_a: assert property ((pa_analog_en & 8'hD0) == 8'h00)
      else $error("analog mode on a digital-only pin");
   od_low_a: assert property (!rst |=>
      ((per_pad_oe_n | per_pad_out) & $past(pull_low)) == 9'h000)
      else $error("low peripheral bit not pulled down");
   drive_release_a: assert property (!rst |=>
      (~per_pad_oe_n & ~$past(per_drive)) == 9'h000)
      else $error("peripheral pad driven without request");
   pmp_change_a: assert property ($changed(pmp_ttl_sel) |-> $past(wr_take, 2))
      else $error("buffer select changed without a write");
endmodule : pca_top_sva

bind pca_top pca_top_sva sva_i (.clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
   .hrdata, .pa_analog_en, .pa_schmitt_en, .per_data, .per_drive, .per_pad_out,
   .per_pad_oe_n, .pmp_ttl_sel);

/* File: tb/pca_ext_model.sv */
// Purpose: Outside logic and board wiring at the pads
// Assumes: Released port pins are driven by outside logic
// Notes: Peripheral lines carry a pull-up to the higher rail
`timescale 1ns/1ps

module pca_ext_model (
   input wire logic [7:0] pa_out,
   input wire logic [7:0] pa_oe_n,
   input wire logic [8:0] per_pad_out,
   input wire logic [8:0] per_pad_oe_n,
   input wire logic [7:0] ext_pa,
   output logic [7:0] pa_in,
   output logic [8:0] per_line
);
   // Released pins show the outside value, never a stale one
   assign pa_in = (pa_oe_n & ext_pa) | (~pa_oe_n & pa_out);
   assign per_line = per_pad_oe_n | per_pad_out;
endmodule : pca_ext_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench for pca_top
// Assumes: 40 MHz clock, AHB-Lite single word transfers
// Notes: Pads settle two edges after a committed write
`timescale 1ns/1ps

module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [8:0] per_data = 9'h000;
   logic [8:0] per_drive = 9'h000;
   logic [7:0] ext_pa = 8'h00;
   logic hreadyout, hresp, pmp_ttl_sel;
   logic [31:0] hrdata;
   logic [7:0] pa_in, pa_out, pa_oe_n, pa_analog_en, pa_schmitt_en;
   logic [8:0] per_pad_out, per_pad_oe_n, per_line;
   int fail_count = 0;
   int n_tests = 0;

   always #12.5 clk = ~clk;

   pca_top uut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pa_in, .pa_out, .pa_oe_n,
      .pa_analog_en, .pa_schmitt_en, .per_data, .per_drive, .per_pad_out,
      .per_pad_oe_n, .pmp_ttl_sel);
   pca_ext_model ext (.pa_out, .pa_oe_n, .per_pad_out, .per_pad_oe_n, .ext_pa, .pa_in,
      .per_line);

   ////////////////////////////////////////
   task automatic report_and_stop();
      if (fail_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fail_count++;
         report_and_stop();
      end
   endtask : wait_rdy

   // Read data is taken at the same edge that ends the data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
         output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      wait_rdy();
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, {24'h0, e});
   endtask : rd_chk

   ////////////////////////////////////////
   task automatic reset_vals();
      chk({24'h0, pa_analog_en}, 32'h2F);
      chk({24'h0, pa_oe_n}, 32'hFF);
      chk({23'h0, per_pad_oe_n}, 32'h1FF);
      chk({31'h0, pmp_ttl_sel}, 32'h0);
      chk({24'h0, pa_schmitt_en}, 32'h10);
      ext_pa <= 8'hFF;
      wr(pca_pkg::OFF_WDT, 8'h10);
      for (int i = 1; i < 5; i++) begin
         rd_chk(8'(i * 4), 8'h00);
      end
      rd_chk(pca_pkg::OFF_PINS, 8'hD0);
      rd_chk(pca_pkg::OFF_DIR, 8'hFF);
   endtask : reset_vals

   task automatic shared_regs();
      logic [7:0] mask [4] = '{8'h1F, 8'h03, 8'h03, 8'h01};
      for (int i = 0; i < 4; i++) begin
         wr(pca_pkg::OFF_WDT, 8'h10);
         wr(8'(4 * i + 4), 8'hFF);
         rd_chk(8'(4 * i + 4), mask[i]);
         wr(pca_pkg::OFF_WDT, 8'h00);
         wr(8'(4 * i + 4), 8'h5A);
         rd_chk(8'(4 * i + 4), 8'h5A);
         wr(pca_pkg::OFF_WDT, 8'h10);
         rd_chk(8'(4 * i + 4), mask[i]);
      end
      wr(8'h40, 8'hFF);
      rd_chk(8'h40, 8'h00);
      chk({31'h0, hresp}, 32'h0);
   endtask : shared_regs

   task automatic open_drain();
      wr(8'h04, 8'h15);
      wr(8'h08, 8'h01);
      wr(8'h0C, 8'h02);
      wr(8'h10, 8'h01);
      per_drive <= 9'h1FF;
      per_data <= 9'h1FF;
      tick(2);
      chk({23'h0, per_pad_oe_n}, 32'h135);
      chk({23'h0, per_pad_out}, 32'h0CA);
      chk({23'h0, per_line}, 32'h1FF);
      chk({31'h0, pmp_ttl_sel}, 32'h1);
      per_data <= 9'h000;
      tick(2);
      chk({23'h0, per_pad_oe_n}, 32'h000);
      chk({23'h0, per_line}, 32'h000);
      per_drive <= 9'h000;
      wr(8'h10, 8'h00);
      tick(2);
      chk({23'h0, per_pad_oe_n}, 32'h1FF);
      chk({31'h0, pmp_ttl_sel}, 32'h0);
   endtask : open_drain

   task automatic port_a();
      ext_pa <= 8'h3C;
      wr(pca_pkg::OFF_ANA, 8'h1F);
      wr(pca_pkg::OFF_DIR, 8'h0F);
      wr(pca_pkg::OFF_PINS, 8'hA5);
      tick(2);
      chk({24'h0, pa_oe_n}, 32'h0F);
      chk({24'h0, pa_out & 8'hF0}, 32'hA0);
      chk({24'h0, pa_analog_en}, 32'h00);
      rd_chk(pca_pkg::OFF_LAT, 8'hA5);
      rd_chk(pca_pkg::OFF_PINS, 8'hAC);
      wr(pca_pkg::OFF_ANA, 8'h00);
      tick(2);
      chk({24'h0, pa_analog_en}, 32'h2F);
      chk({24'h0, pa_oe_n}, 32'h0F);
      rd_chk(pca_pkg::OFF_PINS, 8'h80);
      // Mixed pattern sets pins 1 and 3 analog, pins 0, 2 and 5 digital
      wr(pca_pkg::OFF_ANA, 8'h15);
      tick(2);
      chk({24'h0, pa_analog_en}, 32'h0A);
   endtask : port_a

   task automatic osc_modes();
      logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
      logic [7:0] s;
      // Pin 7 set as input so its stored direction bit must be masked
      wr(pca_pkg::OFF_DIR, 8'hBF);
      wr(pca_pkg::OFF_LAT, 8'hC0);
      foreach (codes[i]) begin
         wr(pca_pkg::OFF_OSC, {5'h0, codes[i]});
         tick(2);
         chk({30'h0, pa_oe_n[7:6]}, codes[i][2] ? 32'h3 : 32'h2);
         rd_chk(pca_pkg::OFF_LAT, codes[i][2] ? 8'h00 : (codes[i][0] ? 8'h80 : 8'hC0));
         rd_chk(pca_pkg::OFF_DIR, codes[i][2] ? 8'h3F : 8'hBF);
         for (int k = 0; k < 8; k++) begin
            s[k] = pa_out[6];
            tick(1);
         end
         if (!codes[i][2]) begin
            chk({31'h0, s inside {8'h33, 8'h66, 8'hCC, 8'h99}}, {31'h0, codes[i][0]});
         end
      end
   endtask : osc_modes

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      reset_vals();
      shared_regs();
      open_drain();
      port_a();
      osc_modes();
      rst <= 1'b1;
      tick(3);
      rst <= 1'b0;
      reset_vals();
      report_and_stop();
   end
endmodule : tb
